/* File: hw/rfr_defines.vh */
// Constants for the clock-calendar flag and register bank.
// Assumes inclusion by bare name from design files under hw/.
//
// How it works
// RULE1: Watchdog, alarm, power events set their flags.
// RULE2: Reading flag register clears the three flags.
// RULE3: Reset loads flags zero except oscillator fail. The code also loads oscillator fail zero, then seeds it once.
// RULE4: Flag bits D7 down to D0 fixed layout.
// RULE5: Alarm date BCD 01-31, mask D7, D6 zero.
// RULE6: Trim magnitude is binary with separate sign.
// RULE7: Software writes zero to unused clock bits.
// RULE8: Oscillator/backup flag clears appear after delay.
// RULE9: Interrupt needs flag set and its enable one.
// RULE10: Pulse mode drives about 200 ms, else level.
// RULE11: Time registers hold BCD, unused bits zero.
`ifndef RFR_DEFINES_VH
`define RFR_DEFINES_VH

// Register indices; the byte address is four times the index.
`define RFR_IDX_FLAG 4'h0
`define RFR_IDX_CENT 4'h1
`define RFR_IDX_ASEC 4'h2
`define RFR_IDX_AMIN 4'h3
`define RFR_IDX_AHOUR 4'h4
`define RFR_IDX_ADATE 4'h5
`define RFR_IDX_IRQ 4'h6
`define RFR_IDX_WDOG 4'h7
`define RFR_IDX_TRIM 4'h8
`define RFR_IDX_SEC 4'h9
`define RFR_IDX_MIN 4'hA
`define RFR_IDX_HOUR 4'hB
`define RFR_IDX_WDAY 4'hC
`define RFR_IDX_MDAY 4'hD
`define RFR_IDX_MON 4'hE
`define RFR_IDX_YEAR 4'hF
// Extra registers: interrupt mask (byte address 0x40) and event status.
`define RFR_ADDR_MASK 12'h040
`define RFR_ADDR_EVT 12'h044

// Flag register bit positions.
`define RFR_FB_WDOG 7
`define RFR_FB_ALARM 6
`define RFR_FB_PFAIL 5
`define RFR_FB_OSC 4
`define RFR_FB_BKUP 3
`define RFR_FB_CALO 2
`define RFR_FB_WHOLD 1
`define RFR_FB_RSNAP 0

// Interrupt control bit positions.
`define RFR_IB_WIE 7
`define RFR_IB_AIE 6
`define RFR_IB_PFE 5
`define RFR_IB_SQUARE_WAVE_ENABLE 4
`define RFR_IB_HIGH 3
`define RFR_IB_PULSE 2

// Reset values.
`define RFR_RST_FLAG 8'h00
`define RFR_RST_IRQ 8'h08
`define RFR_RST_ALARM 8'h80
`define RFR_RST_ZERO 8'h00

// Timing: clock in MHz, pulse width in ms, flag update delay in ns.
`define RFR_CLK_MHZ 250
`define RFR_PULSE_MS 200
`define RFR_FLAG_DLY_NS 1000

`endif

/* File: hw/rfr_sync2.v */
// Two-stage synchroniser for one asynchronous level.
// Assumes the input comes from outside the pclk domain.
`timescale 1ns/100ps
`default_nettype none
module rfr_sync2 (
  input wire pclk,
  input wire presetn,
  input wire d,
  output wire q
);
  // First stage is read only by the second stage.
  reg s1_q;
  reg s2_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // rfr_sync2
`default_nettype wire

/* File: hw/rfr_timer.v */
// Loadable down-counter producing a one-cycle done pulse when it reaches zero.
// Assumes a synchronous start pulse and one clock.
`timescale 1ns/100ps
`default_nettype none
module rfr_timer #(
  parameter W = 32
) (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire abort,
  input wire [W-1:0] load,
  output wire busy,
  output wire done
);
  // Remaining cycles; zero means idle.
  reg [W-1:0] cnt_q;
  reg done_q;
  // Counts down after a start; abort drops it to idle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {W{1'b0}};
      done_q <= 1'b0;
    end else if (abort) begin
      cnt_q <= {W{1'b0}};
      done_q <= 1'b0;
    end else if (start) begin
      cnt_q <= load;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
      if (cnt_q != {W{1'b0}}) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  assign busy = (cnt_q != {W{1'b0}});
  assign done = done_q;
endmodule // rfr_timer
`default_nettype wire

/* File: hw/rfr_regbank.v */
// Clock-calendar register bank with event flags and interrupt driver.
// Assumes an APB master on pclk and event inputs from foreign domains.
`include "rfr_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module rfr_regbank #(
  // Pulse length: milliseconds times cycles per millisecond (MHz times 1000).
  parameter PULSE_CYC = `RFR_PULSE_MS * `RFR_CLK_MHZ * 1000,
  parameter FDLY_CYC = (`RFR_FLAG_DLY_NS * `RFR_CLK_MHZ + 999) / 1000
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire watchdog_expire,
  input wire alarm_match,
  input wire power_trip,
  input wire osc_fail_in,
  input wire backup_fail_in,
  output wire rtc_int_o,
  output wire rtc_int_oe,
  output wire irq
);
  ////////////////////////////////////////////////////////////////////////
  // Bus decode.
  ////////////////////////////////////////////////////////////////////////
  // Access phase strobes; the slave answers with zero wait states.
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  // Register window covers byte addresses 0x00 to 0x3C, word aligned.
  wire in_map = (paddr[11:6] == 6'h00) & (paddr[1:0] == 2'b00);
  wire [3:0] idx = paddr[5:2];
  wire hit_mask = (paddr == `RFR_ADDR_MASK);
  wire hit_evt = (paddr == `RFR_ADDR_EVT);
  wire mapped = in_map | hit_mask | hit_evt;
  // The slave never stretches a transfer beyond its first access cycle.
  assign pready = 1'b1;
  // Unmapped addresses answer with an error.
  assign pslverr = acc & ~mapped;
  wire wr_reg = wr & in_map;
  wire rd_flag = rd & in_map & (idx == `RFR_IDX_FLAG);

  ////////////////////////////////////////////////////////////////////////
  // Event synchronisers.
  ////////////////////////////////////////////////////////////////////////
  // External events come from other domains and pass two flops first.
  wire [4:0] ev_raw = {watchdog_expire, alarm_match, power_trip,
                       osc_fail_in, backup_fail_in};
  wire [4:0] ev_s;
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sync
      rfr_sync2 u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(ev_raw[g]),
        .q(ev_s[g])
      );
    end
  endgenerate
  // Rising-edge detect on synchronised levels only.
  reg [4:0] ev_prev_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_prev_q <= 5'h00;
    end else begin
      ev_prev_q <= ev_s;
    end
  end
  wire [4:0] ev_rise = ev_s & ~ev_prev_q;
  // Vector order: watchdog, alarm, power, oscillator, backup.
  wire ev_wd = ev_rise[4];
  wire ev_al = ev_rise[3];
  wire ev_pf = ev_rise[2];
  wire ev_osc = ev_rise[1];
  wire ev_bk = ev_rise[0];

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  ////////////////////////////////////////////////////////////////////////
  reg [7:0] cent_q; // Century count, BCD.
  reg [7:0] asec_q; // Alarm second with match mask in D7.
  reg [7:0] amin_q; // Alarm minute with match mask in D7.
  reg [7:0] ahour_q; // Alarm hour with match mask in D7.
  reg [7:0] adate_q; // Alarm date with match mask in D7.
  reg [7:0] irqc_q; // Interrupt control.
  reg [7:0] wdog_q; // Watchdog control.
  reg [7:0] trim_q; // Oscillator trim.
  reg [7:0] sec_q; // Time second, BCD.
  reg [7:0] min_q; // Time minute, BCD.
  reg [7:0] hour_q; // Time hour, BCD.
  reg [7:0] wday_q; // Weekday.
  reg [7:0] mday_q; // Month_day, BCD.
  reg [7:0] mon_q; // Month, BCD.
  reg [7:0] year_q; // Year, BCD.
  reg [2:0] mask_q; // Interrupt mask for the bus interrupt.
  reg [2:0] evt_q; // Sticky event status for the bus interrupt.
  wire [7:0] wd8 = pwdata[7:0];
  // Unused time, alarm and trim bits are masked off on write, so they read as zero; interrupt control bits 1:0 are stored as written.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cent_q <= `RFR_RST_ZERO;
      asec_q <= `RFR_RST_ALARM;
      amin_q <= `RFR_RST_ALARM;
      ahour_q <= `RFR_RST_ALARM;
      adate_q <= `RFR_RST_ALARM;
      irqc_q <= `RFR_RST_IRQ;
      wdog_q <= `RFR_RST_ZERO;
      trim_q <= `RFR_RST_ZERO;
      sec_q <= `RFR_RST_ZERO;
      min_q <= `RFR_RST_ZERO;
      hour_q <= `RFR_RST_ZERO;
      wday_q <= `RFR_RST_ZERO;
      mday_q <= `RFR_RST_ZERO;
      mon_q <= `RFR_RST_ZERO;
      year_q <= `RFR_RST_ZERO;
      mask_q <= 3'h0;
    end else if (wr_reg) begin
      case (idx)
        `RFR_IDX_CENT: cent_q <= wd8; // [RULE11]
        `RFR_IDX_ASEC: asec_q <= wd8;
        `RFR_IDX_AMIN: amin_q <= wd8;
        `RFR_IDX_AHOUR: ahour_q <= wd8 & 8'hBF;
        // Date keeps the mask bit and forces D6 to zero.
        `RFR_IDX_ADATE: adate_q <= wd8 & 8'hBF; // [RULE5]
        `RFR_IDX_IRQ: irqc_q <= wd8;
        // Timeout bits change only when the same write holds the gate bit D6 low.
        `RFR_IDX_WDOG: begin
          wdog_q[7:6] <= wd8[7:6];
          if (!wd8[6]) begin
            wdog_q[5:0] <= wd8[5:0];
          end
        end
        // Run control, sign and five-bit binary magnitude.
        `RFR_IDX_TRIM: trim_q <= wd8 & 8'hBF; // [RULE6]
        `RFR_IDX_SEC: sec_q <= wd8 & 8'h7F; // [RULE11]
        `RFR_IDX_MIN: min_q <= wd8 & 8'h7F; // [RULE11]
        `RFR_IDX_HOUR: hour_q <= wd8 & 8'h3F; // [RULE11]
        `RFR_IDX_WDAY: wday_q <= wd8 & 8'h07; // [RULE11]
        `RFR_IDX_MDAY: mday_q <= wd8 & 8'h3F; // [RULE11]
        `RFR_IDX_MON: mon_q <= wd8 & 8'h1F; // [RULE11]
        `RFR_IDX_YEAR: year_q <= wd8; // [RULE11]
        default: cent_q <= cent_q;
      endcase
    end else if (wr & hit_mask) begin
      mask_q <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag status register.
  ////////////////////////////////////////////////////////////////////////
  reg watchdog_timeout_flag_q;
  reg alarm_match_flag_q;
  reg power_fail_flag_q;
  reg oscillator_fail_flag_q;
  reg backup_supply_fail_flag_q;
  reg [2:0] ctl_q; // Calibration output, write hold, read snapshot.
  reg [1:0] pend_clr_q; // Pending clears of oscillator and backup flags.
  wire dly_done;
  // Only the done pulse of the delay timer is used; busy is left open.
  wire clr_req = wr_reg & (idx == `RFR_IDX_FLAG) &
                 (~wd8[`RFR_FB_OSC] | ~wd8[`RFR_FB_BKUP]);
  // Oscillator fail is reset to zero like the others; it is then seeded by a
  // clocked capture of the synchronised oscillator monitor.
  reg osc_seed_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_timeout_flag_q <= 1'b0; // [RULE3]
      alarm_match_flag_q <= 1'b0; // [RULE3]
      power_fail_flag_q <= 1'b0; // [RULE3]
      backup_supply_fail_flag_q <= 1'b0; // [RULE3]
      ctl_q <= 3'h0; // [RULE3]
      oscillator_fail_flag_q <= 1'b0;
      osc_seed_q <= 1'b0;
      pend_clr_q <= 2'b00;
    end else begin
      osc_seed_q <= 1'b1;
      // A set in the same cycle as a read clear wins.
      if (ev_wd) begin
        watchdog_timeout_flag_q <= 1'b1; // [RULE1]
      end else if (rd_flag) begin
        watchdog_timeout_flag_q <= 1'b0; // [RULE2]
      end
      if (ev_al) begin
        alarm_match_flag_q <= 1'b1; // [RULE1]
      end else if (rd_flag) begin
        alarm_match_flag_q <= 1'b0; // [RULE2]
      end
      if (ev_pf) begin
        power_fail_flag_q <= 1'b1; // [RULE1]
      end else if (rd_flag) begin
        power_fail_flag_q <= 1'b0; // [RULE2]
      end
      if (wr_reg && idx == `RFR_IDX_FLAG) begin
        ctl_q <= wd8[2:0];
      end
      // Clears are held pending and applied when the delay expires.
      if (clr_req) begin
        pend_clr_q <= ~{wd8[`RFR_FB_OSC], wd8[`RFR_FB_BKUP]};
      end else if (dly_done) begin
        pend_clr_q <= 2'b00;
      end
      if (!osc_seed_q) begin
        oscillator_fail_flag_q <= ev_s[1];
      end else if (ev_osc) begin
        oscillator_fail_flag_q <= 1'b1;
      end else if (dly_done && pend_clr_q[1]) begin
        oscillator_fail_flag_q <= 1'b0; // [RULE8]
      end
      if (ev_bk) begin
        backup_supply_fail_flag_q <= 1'b1;
      end else if (dly_done && pend_clr_q[0]) begin
        backup_supply_fail_flag_q <= 1'b0; // [RULE8]
      end
    end
  end
  // Delay between the clear request and the visible update.
  rfr_timer #(.W(16)) u_fdly (
    .pclk(pclk),
    .presetn(presetn),
    .start(clr_req),
    .abort(1'b0),
    .load(FDLY_CYC[15:0]),
    .busy(),
    .done(dly_done)
  );
  wire [7:0] flag_v = {watchdog_timeout_flag_q, alarm_match_flag_q,
                       power_fail_flag_q, oscillator_fail_flag_q,
                       backup_supply_fail_flag_q, ctl_q}; // [RULE4]

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pin driver.
  ////////////////////////////////////////////////////////////////////////
  // Only enabled sources reach the pin; a disabled flag stays silent.
  wire src_act = (watchdog_timeout_flag_q & irqc_q[`RFR_IB_WIE]) |
                 (alarm_match_flag_q & irqc_q[`RFR_IB_AIE]) |
                 (power_fail_flag_q & irqc_q[`RFR_IB_PFE]); // [RULE9]
  reg src_prev_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_act;
    end
  end
  wire src_rise = src_act & ~src_prev_q;
  wire pls_busy;
  // Pulse timer starts when the enabled sources go from none to any in pulse mode and ends after PULSE_CYC cycles or on a flag read.
  rfr_timer #(.W(32)) u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .start(src_rise & irqc_q[`RFR_IB_PULSE]),
    .abort(rd_flag),
    .load(PULSE_CYC[31:0]),
    .busy(pls_busy),
    .done()
  );
  // Pulse mode drives for the timer length; level mode while flags set.
  wire int_act = irqc_q[`RFR_IB_PULSE] ? pls_busy : src_act; // [RULE10]
  reg int_q;
  reg int_oe_q;
  // Active high drives push-pull; active low drives only the low level.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_q <= 1'b0;
      int_oe_q <= 1'b0;
    end else if (irqc_q[`RFR_IB_HIGH]) begin
      int_q <= int_act;
      int_oe_q <= 1'b1;
    end else begin
      int_q <= 1'b0;
      int_oe_q <= int_act;
    end
  end
  assign rtc_int_o = int_q;
  assign rtc_int_oe = int_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Bus interrupt: sticky events, write one to clear.
  ////////////////////////////////////////////////////////////////////////
  wire [2:0] ev3 = {ev_wd, ev_al, ev_pf};
  wire [2:0] evt_clr = (wr & hit_evt) ? pwdata[2:0] : 3'h0;
  // An event in the same cycle as its clear keeps the bit set.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 3'h0;
    end else begin
      evt_q <= ev3 | (evt_q & ~evt_clr);
    end
  end
  assign irq = |(evt_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // Read data.
  ////////////////////////////////////////////////////////////////////////
  reg [7:0] rmux;
  // Selects the addressed register; unmapped reads give zero.
  always @* begin
    rmux = 8'h00;
    if (in_map) begin
      case (idx)
        // Events landing in the setup cycle are shown now, because the
        // access edge clears them; a later event survives the clear.
        `RFR_IDX_FLAG: rmux = flag_v | {ev_wd, ev_al, ev_pf, 5'h00}; // [RULE2]
        `RFR_IDX_CENT: rmux = cent_q;
        `RFR_IDX_ASEC: rmux = asec_q;
        `RFR_IDX_AMIN: rmux = amin_q;
        `RFR_IDX_AHOUR: rmux = ahour_q;
        `RFR_IDX_ADATE: rmux = adate_q;
        `RFR_IDX_IRQ: rmux = irqc_q;
        `RFR_IDX_WDOG: rmux = wdog_q;
        `RFR_IDX_TRIM: rmux = trim_q;
        `RFR_IDX_SEC: rmux = sec_q;
        `RFR_IDX_MIN: rmux = min_q;
        `RFR_IDX_HOUR: rmux = hour_q;
        `RFR_IDX_WDAY: rmux = wday_q;
        `RFR_IDX_MDAY: rmux = mday_q;
        `RFR_IDX_MON: rmux = mon_q;
        `RFR_IDX_YEAR: rmux = year_q;
        default: rmux = 8'h00;
      endcase
    end else if (hit_mask) begin
      rmux = {5'h00, mask_q};
    end else if (hit_evt) begin
      rmux = {5'h00, evt_q};
    end
  end
  // Read data is registered in the setup cycle, ready for the access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= {24'h000000, rmux};
    end
  end
endmodule // rfr_regbank
`default_nettype wire

/* File: dv/rfr_regbank_monitor.sv */
// Checker for the register bank ports.
// Assumes a bind onto every rfr_regbank instance.
`timescale 1ns/100ps
`default_nettype none
module rfr_regbank_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic watchdog_expire,
  input wire logic alarm_match,
  input wire logic power_trip,
  input wire logic rtc_int_oe,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase, quiet event lines and a flag read.
  wire acc = psel && penable;
  wire quiet = !watchdog_expire && !alarm_match && !power_trip;
  wire rd_flag = acc && !pwrite && paddr == 12'h000;
  //////////////////////////////////////
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_unmapped: assert property (acc && paddr > 12'h044 |-> pslverr)
    else $error("no error on unmapped access");
  chk_zero_unmapped: assert property
    (acc && !pwrite && paddr > 12'h044 |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (
    acc && !pwrite && paddr < 12'h040 |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_rdata_stands: assert property
    (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside read setup");
  chk_flag_clear: assert property (
    quiet [*6] ##0 rd_flag ##1 (psel && !penable && !pwrite &&
    paddr == 12'h000) ##1 acc |-> prdata[7:5] == 3'h0)
    else $error("event flags survived a read");
  chk_evt_clear: assert property (
    quiet [*6] ##0 acc && pwrite && paddr == 12'h044 &&
    pwdata[2:0] == 3'h7 |=> !irq)
    else $error("irq stayed after status clear");
  chk_mask_off: assert property (
    acc && pwrite && paddr == 12'h040 && pwdata[2:0] == 3'h0 |=> !irq)
    else $error("irq with all sources masked");
  chk_reset_quiet: assert property (
    $rose(presetn) |-> !irq && !rtc_int_oe)
    else $error("outputs active at reset release");
endmodule // rfr_regbank_monitor
bind rfr_regbank rfr_regbank_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .watchdog_expire(watchdog_expire),
  .alarm_match(alarm_match), .power_trip(power_trip),
  .rtc_int_oe(rtc_int_oe), .irq(irq));
`default_nettype wire

/* File: dv/rfr_host_side.sv */
// Model of the board around the bank: event sources and the pin.
// Assumes the bench requests events on its own clock edges.
`timescale 1ns/100ps
`default_nettype none
module rfr_host_side (
  input wire logic [4:0] ev_req,
  input wire logic rtc_int_o,
  input wire logic rtc_int_oe,
  output logic [4:0] ev_line,
  output logic int_pin
);
  // Event levels arrive skewed off the bus clock.
  assign #1.3 ev_line = ev_req;
  // A pull-up holds the line high while nobody drives it.
  assign int_pin = rtc_int_oe ? rtc_int_o : 1'b1;
endmodule // rfr_host_side
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the register bank over APB.
// Assumes the bound checker and the board model beside it.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, rtc_int_o, rtc_int_oe, irq, int_pin;
  logic [4:0] ev_req, ev_line;
  int num_errors = 0;
  int total_checks = 0;
  localparam logic [11:0] A_FLAG = 12'h000;
  localparam logic [11:0] A_MASK = 12'h040;
  localparam logic [11:0] A_EVT = 12'h044;
  // Legal BCD or binary values per index, index 15 first; zero is skipped.
  localparam logic [127:0] LEGAL = {8'h99, 8'h12, 8'h31, 8'h07, 8'h23,
    8'h59, 8'h59, 8'h3F, 8'h00, 8'h00, 8'hB1, 8'h23, 8'h59, 8'hD9,
    8'h99, 8'h00};
  rfr_regbank #(.PULSE_CYC(20), .FDLY_CYC(4)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_expire(ev_line[0]),
    .alarm_match(ev_line[1]), .power_trip(ev_line[2]),
    .osc_fail_in(ev_line[3]), .backup_fail_in(ev_line[4]),
    .rtc_int_o(rtc_int_o), .rtc_int_oe(rtc_int_oe), .irq(irq));
  rfr_host_side u_host (.ev_req(ev_req), .rtc_int_o(rtc_int_o),
    .rtc_int_oe(rtc_int_oe), .ev_line(ev_line), .int_pin(int_pin));
  // The bus clock, 4 ns period.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  //////////////////////////////////////
  task automatic tally_and_finish;
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One transfer; psel stays up so a next one may follow at once.
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    penable <= 1'b0;
  endtask
  task automatic idle;
    psel <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
    idle();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    idle();
    cmp(q & m, e);
  endtask
  // Compares {irq, pin level, pin enable} away from the edge.
  task automatic look(input logic [2:0] m, input logic [2:0] e);
    @(negedge pclk);
    cmp({29'h0, {irq, int_pin, rtc_int_oe} & m}, {29'h0, e});
    @(posedge pclk);
  endtask
  task automatic ev(input logic [4:0] m);
    ev_req <= m;
    cyc(3);
    ev_req <= 5'h00;
    cyc(6);
  endtask
  // Hang guard, far beyond the few hundred cycles needed.
  initial begin
    cyc(20000);
    num_errors++;
    tally_and_finish();
  end
  //////////////////////////////////////
  initial begin
    logic [31:0] q;
    int i;
    {psel, penable, pwrite, presetn} = 4'h0;
    {paddr, pwdata, ev_req} = '0;
    cyc(5);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 16; i++) begin
      rd(12'(4 * i), (i > 1 && i < 6) ? 32'h80 :
         {28'h0, i == 6, 3'h0});
    end
    for (i = 1; i < 16; i++) begin
      if (i != 6 && i != 7) wr(12'(4 * i), LEGAL[8*i +: 8]);
    end
    for (i = 1; i < 16; i++) begin
      if (i != 6 && i != 7) begin
        rd(12'(4 * i), LEGAL[8*i +: 8]);
      end
    end
    wr(12'h01C, 32'h15);
    wr(12'h01C, 32'h6A);
    rd(12'h01C, 32'h15, 32'h3F);
    wr(12'h080, 32'h5A);
    rd(12'h080, 32'h0);
    rd(12'h002, 32'h0);
    // Level mode, active high, all sources enabled.
    wr(A_MASK, 32'h07);
    wr(12'h018, 32'hE8);
    for (i = 0; i < 3; i++) begin
      ev(5'h01 << i);
      look(3'h7, 3'h7);
      cyc(30);
      look(3'h2, 3'h2);
      rd(A_EVT, 32'h4 >> i);
      apb(1'b0, A_FLAG, 32'h0, q);
      cmp(q, 32'h80 >> i);
      apb(1'b0, A_FLAG, 32'h0, q);
      idle();
      cmp(q, 32'h00);
      look(3'h6, 3'h4);
      wr(A_EVT, 32'h7);
      look(3'h4, 3'h0);
    end
    // Source disabled at the pin, then masked at irq.
    wr(12'h018, 32'h08);
    ev(5'h02);
    look(3'h6, 3'h4);
    wr(A_MASK, 32'h0);
    look(3'h4, 3'h0);
    rd(A_FLAG, 32'h40);
    wr(A_EVT, 32'h7);
    // Active low level mode on the open-drain pin.
    wr(A_MASK, 32'h07);
    wr(12'h018, 32'h40);
    ev(5'h02);
    look(3'h3, 3'h1);
    rd(A_FLAG, 32'h40);
    cyc(1);
    look(3'h3, 3'h2);
    // Pulse mode ends by itself without a flag read.
    wr(12'h018, 32'h2C);
    ev(5'h04);
    look(3'h2, 3'h2);
    cyc(25);
    look(3'h2, 3'h0);
    rd(A_FLAG, 32'h20);
    // A flag read cuts a running pulse short.
    ev(5'h04);
    look(3'h2, 3'h2);
    rd(A_FLAG, 32'h20);
    look(3'h2, 3'h0);
    wr(A_EVT, 32'h7);
    // Oscillator and backup flags clear only after a delay.
    ev(5'h18);
    rd(A_FLAG, 32'h18);
    apb(1'b1, A_FLAG, 32'h0, q);
    apb(1'b0, A_FLAG, 32'h0, q);
    idle();
    cmp(q, 32'h18);
    cyc(6);
    rd(A_FLAG, 32'h00);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
